/* File: core/ovp_seq_defs.svh */
// timing constants of the overvoltage protect sequencer
// assumes a 50 MHz core clock; included by the package and the top module
`ifndef OVP_SEQ_DEFS_SVH
`define OVP_SEQ_DEFS_SVH

`define CLK_PERIOD_NS 20
// startup delay, typical, in milliseconds
`define STARTUP_DELAY_MS 50
// fault blanking time, typical, in milliseconds
`define FAULT_BLANKING_TIME_MS 50
// delays in cycles, derived from the times above
`define STARTUP_DELAY_CYC ((`STARTUP_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define FAULT_BLANKING_CYC ((`FAULT_BLANKING_TIME_MS * 1000000) / `CLK_PERIOD_NS)
// cycles the pin synchroniser needs before it carries real levels after reset
`define SYNC_FLUSH_CYC 2
// timer width, enough for 2500000 cycles
`define DELAY_TIMER_W 22

`endif

/* File: core/ovp_seq_pkg.sv */
// types of the overvoltage protect sequencer
// assumes ovp_seq_defs.svh on the include path
`include "ovp_seq_defs.svh"

package ovp_seq_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    st_power_up,
    st_lockout,
    st_startup_wait,
    st_blanking,
    st_on,
    st_shutdown
  } seq_state_type;

  // comparator results from the analog front end
  typedef struct packed {
    logic undervoltage_lockout;
    logic overvoltage_lockout;
    logic below_ground;
  } sense_type;

  // drive outputs toward the switches and host
  typedef struct packed {
    logic nswitch_gate_drive;
    logic pswitch_gate_drive;
    logic fault_flag_oe;
  } drive_type;

endpackage

/* File: core/input_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs asynchronous to clk_i
`timescale 1ns/10ps

module input_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // asynchronous inputs and synchronised outputs
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type state_reg;
  sync_state_type state_next;

  // first stage feeds only the second
  always_comb begin
    state_next = state_reg;
    state_next.meta = async_i;
    state_next.stable = state_reg.meta;
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stable;

endmodule

/* File: core/overvoltage_protect_sequencer.sv */
// sequencing logic of an input overvoltage / reverse polarity protection controller
// assumes comparator results and shutdown request arrive asynchronously on pins
// assumes one free-running core clock; every delay is counted in its cycles
// assumes the host pulls the fault flag line up while it is released
// assumes the comparators carry their own hysteresis
//
// Contract
// [R1] valid window held for startup delay before raising n-switch gate drive
// [R2] fault indicator stays asserted for blanking time after gate turn-on
// [R3] overvoltage or undervoltage asserts fault indicator with no timer
// [R4] undervoltage in any state asserts fault and forces n-switch gate low
// [R5] overvoltage holds n-switch gate low and fault asserted
// [R6] after fault clears, on-sequence restarts; fault clears blanking after gate on
// [R7] at power-up outside window, gate off and fault asserted
// [R8] on-state entered only after blanking period expires
// [R9] overvoltage during power-up pulls gate down within initial fault delay
// [R10] shutdown request high disables device and turns off n-switch gate
// [R11] shutdown request high releases fault indicator regardless of inputs
// [R12] fault indicator open drain: released when asserted, pulled low deasserted
// [R13] p-switch gate high below ground, low above ground
// [R14] inputs synchronised; both timers restart from zero on fault or shutdown
`timescale 1ns/10ps
`include "ovp_seq_defs.svh"

module overvoltage_protect_sequencer
  import ovp_seq_pkg::*;
#(
  parameter int STARTUP_CYCLES = `STARTUP_DELAY_CYC,
  parameter int BLANKING_CYCLES = `FAULT_BLANKING_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // comparator results and host shutdown request
  input wire ovp_seq_pkg::sense_type sense_i,
  input wire logic shutdown_req_i,
  // switch gate drives
  output logic nswitch_gate_drive_o,
  output logic pswitch_gate_drive_o,
  // open-drain fault indicator: output level and enable
  output logic fault_flag_o,
  output logic fault_flag_oe_o,
  // current sequencer state for observation
  output ovp_seq_pkg::seq_state_type seq_state_o
);

  import ovp_seq_pkg::*;

  // all sequencer state in one word; the flag data level is registered too
  typedef struct packed {
    seq_state_type state;
    logic [`DELAY_TIMER_W-1:0] timer;
    drive_type drive;
    logic flag_level;
  } seq_reg_type;

  seq_reg_type seq_reg;
  seq_reg_type seq_next;

  // pin levels before and after the synchroniser
  logic [3:0] pin_bits;
  logic [3:0] sync_bits;
  logic uv;
  logic ov;
  logic below_gnd;
  logic shut;

  // fault summary, timer arithmetic and timer end points
  logic fault;
  logic window_ok;
  logic fault_hit;
  logic startup_last_hit;
  logic blank_last_hit;
  logic flush_done;
  logic [`DELAY_TIMER_W-1:0] timer_inc;
  logic [`DELAY_TIMER_W-1:0] startup_last;
  logic [`DELAY_TIMER_W-1:0] blank_last;
  logic [`DELAY_TIMER_W-1:0] flush_last;

  // pin order into the synchroniser, msb first
  assign pin_bits[3] = sense_i.undervoltage_lockout;
  assign pin_bits[2] = sense_i.overvoltage_lockout;
  assign pin_bits[1] = sense_i.below_ground;
  assign pin_bits[0] = shutdown_req_i;

  // comparator and shutdown inputs pass two flip-flops
  input_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(pin_bits),
    .sync_o(sync_bits)
  ); // R14

  // synchronised levels and the fault summary
  assign uv = sync_bits[3];
  assign ov = sync_bits[2];
  assign below_gnd = sync_bits[1];
  assign shut = sync_bits[0];
  assign fault = uv | ov; // R3
  assign window_ok = !fault && !shut;

  // terminal counts of the timers, cut to the timer width on purpose
  assign startup_last = `DELAY_TIMER_W'(STARTUP_CYCLES - 1);
  assign blank_last = `DELAY_TIMER_W'(BLANKING_CYCLES - 1);
  assign flush_last = `DELAY_TIMER_W'(`SYNC_FLUSH_CYC - 1);

  // timer step, end points and the fault override, named for the state logic
  assign timer_inc = seq_reg.timer + `DELAY_TIMER_W'(1);
  assign startup_last_hit = (seq_reg.timer == startup_last);
  assign blank_last_hit = (seq_reg.timer == blank_last);
  assign flush_done = (seq_reg.timer == flush_last);
  assign fault_hit = fault && (seq_reg.state != st_power_up) &&
                     (seq_reg.state != st_shutdown);

  // next state, timer and drives; power-up waits until the synchroniser is flushed
  always_comb begin
    seq_next = seq_reg;
    unique case (seq_reg.state)
      st_power_up: begin
        if (flush_done) begin
          seq_next.state = st_lockout; // R7
          seq_next.timer = '0;
        end else begin
          seq_next.timer = timer_inc;
        end
      end
      st_lockout: begin
        seq_next.timer = '0;
        if (window_ok) begin
          seq_next.state = st_startup_wait; // R6
        end
      end
      st_startup_wait: begin
        if (startup_last_hit) begin
          seq_next.state = st_blanking; // R1
          seq_next.timer = '0;
        end else begin
          seq_next.timer = timer_inc;
        end
      end
      st_blanking: begin
        if (blank_last_hit) begin
          seq_next.state = st_on; // R8
          seq_next.timer = '0;
        end else begin
          seq_next.timer = timer_inc; // R2
        end
      end
      st_on: begin
        seq_next.timer = '0;
      end
      st_shutdown: begin
        seq_next.timer = '0;
        if (!shut) begin
          seq_next.state = st_lockout;
        end
      end
      default: begin
        seq_next.state = st_lockout; // illegal codes fall back safe
        seq_next.timer = '0;
      end
    endcase
    // faults override every state but power-up and shutdown, restarting the timers
    if (fault_hit) begin
      seq_next.state = st_lockout; // R4 R5 R9
      seq_next.timer = '0; // R14
    end
    // shutdown overrides everything
    if (shut) begin
      seq_next.state = st_shutdown; // R10
      seq_next.timer = '0; // R14
    end
    // gate drive follows the next state so the output changes with it
    unique case (seq_next.state)
      st_blanking, st_on: begin
        seq_next.drive.nswitch_gate_drive = 1'b1; // R1 R8
      end
      default: begin
        seq_next.drive.nswitch_gate_drive = 1'b0; // R4 R5 R7 R10
      end
    endcase
    seq_next.drive.pswitch_gate_drive = below_gnd; // R13
    // flag pulled low only in the on-state; released (asserted) elsewhere
    unique case (seq_next.state)
      st_on: begin
        seq_next.drive.fault_flag_oe = 1'b1; // R2 R6 R8 R12
      end
      default: begin
        seq_next.drive.fault_flag_oe = 1'b0; // R3 R11
      end
    endcase
    seq_next.flag_level = 1'b0; // R12
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      seq_reg.state <= st_power_up;
      seq_reg.timer <= '0;
      seq_reg.drive.nswitch_gate_drive <= 1'b0; // R7
      seq_reg.drive.pswitch_gate_drive <= 1'b0;
      seq_reg.drive.fault_flag_oe <= 1'b0; // R7
      seq_reg.flag_level <= 1'b0;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // outputs straight from flip-flops; flag pin only ever pulls low
  assign nswitch_gate_drive_o = seq_reg.drive.nswitch_gate_drive;
  assign pswitch_gate_drive_o = seq_reg.drive.pswitch_gate_drive;
  assign fault_flag_o = seq_reg.flag_level; // R12
  assign fault_flag_oe_o = seq_reg.drive.fault_flag_oe;
  assign seq_state_o = seq_reg.state;

endmodule

/* File: testbench/ovp_seq_checker.sv */
// port assertions for the overvoltage protect sequencer
// assumes binding onto the sequencer top with its timing parameters
`timescale 1ns/10ps
module ovp_seq_checker
  import ovp_seq_pkg::*;
#(
  parameter int STARTUP_CYCLES = 20,
  parameter int BLANKING_CYCLES = 30
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire ovp_seq_pkg::sense_type sense_i,
  input wire logic shutdown_req_i,
  input wire logic nswitch_gate_drive_o,
  input wire logic pswitch_gate_drive_o,
  input wire logic fault_flag_o,
  input wire logic fault_flag_oe_o,
  input wire ovp_seq_pkg::seq_state_type seq_state_o
);
  int vcnt_reg;
  int gcnt_reg;
  logic ok;
  logic uv;
  logic ov;
  logic bg;
  assign uv = sense_i.undervoltage_lockout;
  assign ov = sense_i.overvoltage_lockout;
  assign bg = sense_i.below_ground;
  assign ok = !uv && !ov && !shutdown_req_i;
  // run lengths of the valid window and of the gate being on
  always_ff @(posedge clk_i) begin
    vcnt_reg <= (!rst_b_i || !ok) ? 0 : vcnt_reg + 1;
    gcnt_reg <= (!rst_b_i || !nswitch_gate_drive_o) ? 0 : gcnt_reg + 1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_OV_OFF: assert property (
    ov [*4] |-> !nswitch_gate_drive_o && !fault_flag_oe_o) else $error("ov not obeyed");
  AST_UV_OFF: assert property (
    uv [*4] |-> !nswitch_gate_drive_o && !fault_flag_oe_o) else $error("uv not obeyed");
  AST_SHUT_OFF: assert property (
    shutdown_req_i [*4] |-> !nswitch_gate_drive_o && !fault_flag_oe_o) else $error("shutdown");
  AST_FLAG_LOW: assert property (
    fault_flag_o == 1'b0) else $error("flag data not low");
  AST_PSW_OFF: assert property (
    bg [*4] |-> pswitch_gate_drive_o) else $error("pswitch not off");
  AST_PSW_ON: assert property (
    !bg [*4] |-> !pswitch_gate_drive_o) else $error("pswitch not on");
  AST_START_MIN: assert property (
    $rose(nswitch_gate_drive_o) |-> vcnt_reg >= STARTUP_CYCLES) else $error("gate early");
  AST_START_MAX: assert property (
    vcnt_reg == STARTUP_CYCLES + 10 |-> nswitch_gate_drive_o) else $error("gate late");
  AST_ON_STATE: assert property (
    $rose(fault_flag_oe_o) |-> seq_state_o == st_on && gcnt_reg >= BLANKING_CYCLES - 1)
    else $error("flag cleared early");
  AST_BLANK_MAX: assert property (
    gcnt_reg == BLANKING_CYCLES + 4 |-> fault_flag_oe_o) else $error("flag cleared late");
endmodule

bind overvoltage_protect_sequencer ovp_seq_checker #(
  .STARTUP_CYCLES(STARTUP_CYCLES),
  .BLANKING_CYCLES(BLANKING_CYCLES)
) chk (.*);

/* File: testbench/host_flag_model.sv */
// host side of the fault flag: pull-up on the open-drain line
// assumes oe high while the sequencer pulls the line
`timescale 1ns/10ps
module host_flag_model (
  // open-drain drive from the sequencer
  input wire logic flag_i,
  input wire logic flag_oe_i,
  // level seen by the host
  output logic flag_line_o
);
  // pull-up wins whenever the pin is released
  assign flag_line_o = flag_oe_i ? flag_i : 1'b1;
endmodule

/* File: testbench/overvoltage_protect_sequencer_tb_top.sv */
// self-checking bench for the sequencer with a run-length model
// assumes the package, design, checker and host model compiled first
`timescale 1ns/10ps
module overvoltage_protect_sequencer_tb_top;
  import ovp_seq_pkg::*;
  localparam int SC = 20;
  localparam int BC = 30;
  logic clk_i = 0;
  logic rst_b_i = 0;
  sense_type sense_i = '0;
  logic shutdown_req_i = 0;
  logic gate, psw, fdat, foe, fline;
  seq_state_type st;
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'h462e;
  int vcnt = 0;
  int r;
  always #10 clk_i = ~clk_i;
  // model: run length of the valid window on the edges the design samples
  always @(posedge clk_i) begin
    vcnt <= (!rst_b_i || shutdown_req_i || sense_i.undervoltage_lockout ||
             sense_i.overvoltage_lockout) ? 0 : vcnt + 1;
  end
  overvoltage_protect_sequencer #(.STARTUP_CYCLES(SC), .BLANKING_CYCLES(BC)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sense_i(sense_i), .shutdown_req_i(shutdown_req_i),
    .nswitch_gate_drive_o(gate), .pswitch_gate_drive_o(psw), .fault_flag_o(fdat),
    .fault_flag_oe_o(foe), .seq_state_o(st));
  host_flag_model host (.flag_i(fdat), .flag_oe_i(foe), .flag_line_o(fline));
  task automatic chk(input logic s, input logic e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // v is {shutdown, uv, ov, below ground}: driven at a rising edge, checked at a falling one
  task automatic hold(input logic [3:0] v, input int n);
    @(posedge clk_i);
    sense_i <= v[2:0];
    shutdown_req_i <= v[3];
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    if (vcnt < SC || vcnt >= SC + 10) chk(gate, vcnt >= SC + 10);
    if (vcnt < SC + BC || vcnt >= SC + BC + 10) begin
      chk(foe, vcnt >= SC + BC + 10);
      chk(fline, vcnt < SC + BC + 10);
      chk(st == st_on, vcnt >= SC + BC + 10);
    end
    chk(psw, v[0] && rst_b_i);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1;
    hold(4'h4, 6);
    hold(4'h0, 32);
    hold(4'h0, 30);
    hold(4'h2, 6);
    hold(4'h1, 70);
    hold(4'h4, 6);
    hold(4'h0, 70);
    hold(4'h8, 6);
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      hold({r[3] & r[4], r[2] & r[5], r[1] & r[6], r[0]}, r[7] ? 6 : 70);
    end
    // reset again mid-run: outputs at reset levels, then a clean restart
    @(posedge clk_i);
    rst_b_i <= 0;
    hold(4'h1, 6);
    @(posedge clk_i);
    rst_b_i <= 1;
    hold(4'h0, 70);
    finish_test;
  end
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
endmodule
